// ==== pkg/psc_defines.svh ====
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

// Dual-channel discrepancy time and its cycle count at 100 MHz
`define PSC_CLK_PERIOD_NS 10
`define PSC_DISCREP_MS 500
`define PSC_DISCREP_CYC ((`PSC_DISCREP_MS * 1000000) / `PSC_CLK_PERIOD_NS)
// Width of the discrepancy counter
`define PSC_DISCREP_W 26

`endif

// ==== pkg/psc_pkg.sv ====
package psc_pkg;
    typedef enum {
        PSC_IDLE,
        PSC_ARMED,
        PSC_DOWN,
        PSC_UP,
        PSC_WAIT_MUTE,
        PSC_STOPPED,
        PSC_RECOVER
    } psc_state_e;
endpackage : psc_pkg

// ==== pkg/psc_dual_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// Carries one dual-channel safety input to its checker
interface psc_dual_if;
    logic ch_a;
    logic ch_b;
    logic on;
    logic fault;
    modport chk (input ch_a, input ch_b, output on, output fault);
    modport user (output ch_a, output ch_b, input on, input fault);
endinterface : psc_dual_if
`default_nettype wire

// ==== hdl/psc_dual_chan.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "psc_defines.svh"
// Dual-channel safety input: on only with both channels on
module psc_dual_chan #(
    parameter int DISCREP_CYC = `PSC_DISCREP_CYC
) (
    input wire logic clk, // System clock
    input wire logic resetn, // Synchronous reset, active low
    psc_dual_if.chk d // Synchronised channels and result
);
    logic [`PSC_DISCREP_W-1:0] cnt_q;
    logic lock_q;

    // Mismatch longer than the window locks off until both channels drop
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_q <= '0;
            lock_q <= 1'b0;
        end else if (d.ch_a == d.ch_b) begin
            cnt_q <= '0;
            if (!d.ch_a) begin
                lock_q <= 1'b0;
            end
        end else if (cnt_q >= `PSC_DISCREP_W'(DISCREP_CYC - 1)) begin
            lock_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + `PSC_DISCREP_W'(1);
        end
    end

    assign d.on = d.ch_a && d.ch_b && !lock_q;
    assign d.fault = lock_q;

    on_needs_both_a: assert property (@(posedge clk) disable iff (!resetn)
        d.on |-> (d.ch_a && d.ch_b)) else $error("dual input on with a channel off");
endmodule : psc_dual_chan
`default_nettype wire

// ==== hdl/psc_press.sv ====
// Overview of operation
// - The block arms when both stops and top of stroke are on and manual reset is then pressed.
// - Armed at top of stroke, a rising cycle start turns the downstroke output on.
// - In downstroke, bottom of stroke on swaps downstroke off and upstroke on.
// - In upstroke, top of stroke on turns upstroke off and ends the cycle.
// - Releasing cycle start after the downstroke began does not interrupt the stroke.
// - The next cycle needs the optical stop to go off and on, then cycle start again.
// - A stop lost during a stroke halts motion; after manual reset, cycle start drives upstroke.
// - Cycle start and emergency stop are dual two-terminal, optical stop dual PNP, others single.
`timescale 1ns/100ps
`default_nettype none
`include "psc_defines.svh"
module psc_press #(
    parameter int DISCREP_CYC = `PSC_DISCREP_CYC
) (
    input wire logic CLK, // 100 MHz clock
    input wire logic RESETN, // Synchronous reset, active low
    input wire logic CYCLE_START_INPUT_A, // Cycle start channel A
    input wire logic CYCLE_START_INPUT_B, // Cycle start channel B
    input wire logic NONMUTABLE_STOP_INPUT_A, // Emergency stop channel A, on = safe
    input wire logic NONMUTABLE_STOP_INPUT_B, // Emergency stop channel B
    input wire logic OPTICAL_STOP_INPUT_A, // Optical stop PNP channel A, on = clear
    input wire logic OPTICAL_STOP_INPUT_B, // Optical stop PNP channel B
    input wire logic TOP_OF_STROKE_INPUT, // Top of stroke switch
    input wire logic BOTTOM_OF_STROKE_INPUT, // Bottom of stroke switch
    input wire logic MANUAL_RESET_INPUT, // Manual reset button
    output logic DOWNSTROKE_OUTPUT, // Downstroke valve
    output logic UPSTROKE_OUTPUT, // Upstroke valve
    output logic ARMED_OUTPUT, // Block armed and running
    output logic INPUT_FAULT_OUTPUT // Dual-channel discrepancy
);
    localparam int NPIN = 9;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1_q, s2_q, s3_q, pin_q;
    psc_dual_if cs_if ();
    psc_dual_if es_if ();
    psc_dual_if op_if ();
    psc_pkg::psc_state_e st_q, st_d;
    logic cs_prev_q, op_prev_q, mr_prev_q;
    logic cs_rise, op_rise, mr_rise, stops_ok;
    logic dn_d, up_d, dn_q, up_q;

    assign pin_raw = {MANUAL_RESET_INPUT, BOTTOM_OF_STROKE_INPUT, TOP_OF_STROKE_INPUT,
                      OPTICAL_STOP_INPUT_B, OPTICAL_STOP_INPUT_A, NONMUTABLE_STOP_INPUT_B,
                      NONMUTABLE_STOP_INPUT_A, CYCLE_START_INPUT_B, CYCLE_START_INPUT_A};

    // Three-stage synchroniser; a change counts once stages two and three agree
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            pin_q <= '0;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < NPIN; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    pin_q[i] <= s3_q[i];
                end
            end
        end
    end

    // Dual-channel safety inputs
    assign cs_if.ch_a = pin_q[0];
    assign cs_if.ch_b = pin_q[1];
    assign es_if.ch_a = pin_q[2];
    assign es_if.ch_b = pin_q[3];
    assign op_if.ch_a = pin_q[4];
    assign op_if.ch_b = pin_q[5];

    psc_dual_chan #(.DISCREP_CYC(DISCREP_CYC)) u_cs (.clk(CLK), .resetn(RESETN), .d(cs_if.chk));
    psc_dual_chan #(.DISCREP_CYC(DISCREP_CYC)) u_es (.clk(CLK), .resetn(RESETN), .d(es_if.chk));
    psc_dual_chan #(.DISCREP_CYC(DISCREP_CYC)) u_op (.clk(CLK), .resetn(RESETN), .d(op_if.chk));

    // Edge history; starts high, but pin_q resets low, so an input held through reset still gives an edge once synchronised
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            cs_prev_q <= 1'b1;
            op_prev_q <= 1'b1;
            mr_prev_q <= 1'b1;
        end else begin
            cs_prev_q <= cs_if.on;
            op_prev_q <= op_if.on;
            mr_prev_q <= pin_q[8];
        end
    end

    assign cs_rise = cs_if.on && !cs_prev_q;
    assign op_rise = op_if.on && !op_prev_q;
    assign mr_rise = pin_q[8] && !mr_prev_q;
    assign stops_ok = es_if.on && op_if.on;

    // Stroke sequencer
    always_comb begin
        st_d = st_q;
        case (st_q)
            psc_pkg::PSC_IDLE: begin
                if (stops_ok && pin_q[6] && mr_rise) begin
                    st_d = psc_pkg::PSC_ARMED;
                end
            end
            psc_pkg::PSC_ARMED: begin
                if (!stops_ok) begin
                    st_d = psc_pkg::PSC_IDLE;
                end else if (cs_rise && pin_q[6]) begin
                    st_d = psc_pkg::PSC_DOWN;
                end
            end
            psc_pkg::PSC_DOWN: begin
                // Cycle start is not looked at here; release cannot stop it
                if (!stops_ok) begin
                    st_d = psc_pkg::PSC_STOPPED;
                end else if (pin_q[7]) begin
                    st_d = psc_pkg::PSC_UP;
                end
            end
            psc_pkg::PSC_UP: begin
                if (!stops_ok) begin
                    st_d = psc_pkg::PSC_STOPPED;
                end else if (pin_q[6]) begin
                    st_d = psc_pkg::PSC_WAIT_MUTE;
                end
            end
            psc_pkg::PSC_WAIT_MUTE: begin
                // Optical stop must cycle before the next stroke
                if (!es_if.on) begin
                    st_d = psc_pkg::PSC_IDLE;
                end else if (op_rise) begin
                    st_d = psc_pkg::PSC_ARMED;
                end
            end
            psc_pkg::PSC_STOPPED: begin
                if (stops_ok && mr_rise) begin
                    st_d = psc_pkg::PSC_RECOVER;
                end
            end
            psc_pkg::PSC_RECOVER: begin
                if (!stops_ok) begin
                    st_d = psc_pkg::PSC_STOPPED;
                end else if (cs_rise) begin
                    st_d = psc_pkg::PSC_UP;
                end
            end
            default: st_d = psc_pkg::PSC_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            st_q <= psc_pkg::PSC_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs from next state; downstroke and upstroke never both on by construction
    assign dn_d = (st_d == psc_pkg::PSC_DOWN);
    assign up_d = (st_d == psc_pkg::PSC_UP) && !dn_d;

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            dn_q <= 1'b0;
            up_q <= 1'b0;
            ARMED_OUTPUT <= 1'b0;
            INPUT_FAULT_OUTPUT <= 1'b0;
        end else begin
            dn_q <= dn_d;
            up_q <= up_d;
            ARMED_OUTPUT <= (st_d != psc_pkg::PSC_IDLE) && (st_d != psc_pkg::PSC_STOPPED);
            INPUT_FAULT_OUTPUT <= cs_if.fault || es_if.fault || op_if.fault;
        end
    end

    assign DOWNSTROKE_OUTPUT = dn_q;
    assign UPSTROKE_OUTPUT = up_q;

    never_both_a: assert property (@(posedge CLK) disable iff (!RESETN)
        !(dn_q && up_q)) else $error("down and up on together");
    down_start_a: assert property (@(posedge CLK) disable iff (!RESETN)
        (st_q == psc_pkg::PSC_ARMED && stops_ok && cs_rise && pin_q[6]) |=> dn_q)
        else $error("downstroke did not start");
    bottom_swap_a: assert property (@(posedge CLK) disable iff (!RESETN)
        (st_q == psc_pkg::PSC_DOWN && stops_ok && pin_q[7]) |=> (up_q && !dn_q))
        else $error("no reversal at bottom");
    top_end_a: assert property (@(posedge CLK) disable iff (!RESETN)
        (st_q == psc_pkg::PSC_UP && stops_ok && pin_q[6]) |=> !up_q)
        else $error("upstroke not ended at top");
    arm_cause_a: assert property (@(posedge CLK) disable iff (!RESETN)
        (st_q == psc_pkg::PSC_IDLE && st_d == psc_pkg::PSC_ARMED) |-> (mr_rise && stops_ok && pin_q[6]))
        else $error("armed without reset");
    hold_down_a: assert property (@(posedge CLK) disable iff (!RESETN)
        (dn_q && $fell(cs_if.on) && stops_ok && !pin_q[7]) |=> dn_q)
        else $error("release stopped stroke");
    stop_halt_a: assert property (@(posedge CLK) disable iff (!RESETN)
        ((dn_q || up_q) && !stops_ok) |=> (!dn_q && !up_q))
        else $error("motion not halted");
    mute_cycle_a: assert property (@(posedge CLK) disable iff (!RESETN)
        (st_q == psc_pkg::PSC_WAIT_MUTE && !op_rise) |=> !dn_q)
        else $error("new cycle without optical cycle");
endmodule : psc_press
`default_nettype wire

// ==== testbench/psc_ram_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Ram and its two travel switches, driven by the block's valves
module psc_ram_model #(
    parameter int TRAVEL = 16
) (
    input wire logic clk, // Clock
    input wire logic down_on, // Down valve
    input wire logic up_on, // Up valve
    output logic top_sw, // Top of stroke switch
    output logic bottom_sw // Bottom of stroke switch
);
    int pos = 0;
    // Random steps make strokes run both fast and slow; a real ram never jumps
    always @(posedge clk) begin
        if (down_on && !up_on && pos < TRAVEL && $urandom_range(1, 0) == 1) begin
            pos <= pos + 1;
        end else if (up_on && !down_on && pos > 0 && $urandom_range(1, 0) == 1) begin
            pos <= pos - 1;
        end
    end
    // Single-channel switches, only at the two ends of travel
    assign top_sw = (pos == 0);
    assign bottom_sw = (pos == TRAVEL);
endmodule : psc_ram_model
`default_nettype wire

// ==== testbench/tb_psc_press.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_psc_press;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic cs = 1'b0;
    logic es_a = 1'b0;
    logic es_b = 1'b0;
    logic op = 1'b0;
    logic mr = 1'b0;
    logic top_sw, bottom_sw, dn, up, armed, fault;
    int bad_count = 0;
    int num_checks = 0;
    // Paired channels are driven together so only the e-stop test skews them
    psc_press #(.DISCREP_CYC(20)) u_psc_press (
        .CLK(clk), .RESETN(resetn), .CYCLE_START_INPUT_A(cs), .CYCLE_START_INPUT_B(cs),
        .NONMUTABLE_STOP_INPUT_A(es_a), .NONMUTABLE_STOP_INPUT_B(es_b),
        .OPTICAL_STOP_INPUT_A(op), .OPTICAL_STOP_INPUT_B(op), .TOP_OF_STROKE_INPUT(top_sw),
        .BOTTOM_OF_STROKE_INPUT(bottom_sw), .MANUAL_RESET_INPUT(mr), .DOWNSTROKE_OUTPUT(dn),
        .UPSTROKE_OUTPUT(up), .ARMED_OUTPUT(armed), .INPUT_FAULT_OUTPUT(fault)
    );
    psc_ram_model u_psc_ram_model (
        .clk(clk), .down_on(dn), .up_on(up), .top_sw(top_sw), .bottom_sw(bottom_sw)
    );
    // Clock
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic bad(input string msg);
        bad_count++;
        $display("MISMATCH at %0t: %s", $time, msg);
    endtask : bad
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // Reset button press long enough to pass the input synchronisers
    task automatic mr_pulse();
        tick(1);
        mr <= 1'b1;
        tick(8);
        mr <= 1'b0;
        tick(8);
    endtask : mr_pulse
    // Without hold: bounded wait for the outputs; with hold: they must not move
    task automatic expect_out(input logic d, input logic u, input logic a, input bit hold);
        bit hit;
        hit = 1'b0;
        for (int i = 0; i < 100 && !hit; i++) begin
            @(negedge clk);
            if (dn === d && up === u && armed === a) hit = !hold;
            else if (hold) bad("outputs moved");
        end
        num_checks++;
        // A wait that runs out ends the run; later steps would only cascade
        if (!hit && !hold) begin
            bad("outputs did not settle");
            report_and_stop();
        end
        tick(1);
    endtask : expect_out
    // Bounded wait for the fault flag
    task automatic expect_fault(input logic v);
        int i;
        for (i = 0; i < 80 && fault !== v; i++) @(negedge clk);
        num_checks++;
        if (fault !== v) begin
            bad("fault flag wrong");
            report_and_stop();
        end
        tick(1);
    endtask : expect_fault
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    // Both valves on together would fight the cylinder
    always @(negedge clk) begin
        if (resetn && dn === 1'b1 && up === 1'b1) bad("both valves on");
    end
    // Main sequence
    initial begin
        void'($urandom(32'hd85b));
        tick(6);
        resetn <= 1'b1;
        es_a <= 1'b1;
        es_b <= 1'b1;
        tick(10);
        mr_pulse();
        expect_out(1'b0, 1'b0, 1'b0, 1'b1);
        op <= 1'b1;
        tick(10);
        mr_pulse();
        expect_out(1'b0, 1'b0, 1'b1, 1'b0);
        cs <= 1'b1;
        expect_out(1'b1, 1'b0, 1'b1, 1'b0);
        tick($urandom_range(4, 0));
        cs <= 1'b0;
        // Releasing the start button must not stop the stroke
        for (int i = 0; i < 100 && bottom_sw !== 1'b1; i++) begin
            @(negedge clk);
            num_checks++;
            if (dn !== 1'b1) bad("downstroke interrupted");
        end
        // Ram never reached the bottom switch: count it and stop
        if (bottom_sw !== 1'b1) begin
            bad("ram did not reach bottom");
            report_and_stop();
        end
        expect_out(1'b0, 1'b1, 1'b1, 1'b0);
        expect_out(1'b0, 1'b0, 1'b1, 1'b0);
        tick(10);
        cs <= 1'b1;
        expect_out(1'b0, 1'b0, 1'b1, 1'b1);
        cs <= 1'b0;
        tick(10);
        op <= 1'b0;
        tick(10);
        op <= 1'b1;
        tick(10);
        cs <= 1'b1;
        expect_out(1'b1, 1'b0, 1'b1, 1'b0);
        tick(4);
        op <= 1'b0;
        expect_out(1'b0, 1'b0, 1'b0, 1'b0);
        op <= 1'b1;
        cs <= 1'b0;
        tick(10);
        mr_pulse();
        expect_out(1'b0, 1'b0, 1'b1, 1'b0);
        cs <= 1'b1;
        expect_out(1'b0, 1'b1, 1'b1, 1'b0);
        expect_out(1'b0, 1'b0, 1'b1, 1'b0);
        es_a <= 1'b0;
        expect_out(1'b0, 1'b0, 1'b0, 1'b0);
        expect_fault(1'b1);
        es_b <= 1'b0;
        expect_fault(1'b0);
        report_and_stop();
    end
endmodule : tb_psc_press
`default_nettype wire
